// [src/sbi_irq.sv]
// Purpose: Slip-buffer and interworking interrupt enables, status and output
// Assumes: Classic Wishbone, one register per aligned word, 8 data bits used
// Notes: Status flags clear on read and on write-one; a set in the same cycle wins
//
// Operation
// - TX full plus write: drop frame, flag
// - TX empty plus read: repeat frame, flag
// - RX full plus write: drop frame, flag
// - RX empty plus read: repeat frame, flag
// - Either slip event sets direction slip flag
// - TX enables bits 7..5, reset zero
// - RX enables bits 2..0, read/write
// - Bit 7 shows alternating pattern live
// - Bit 6 latches pattern start or stop
// - Flags read one once, clear on read
// - Bit 5 shows interworking state
// - No multiframe lock in 400ms: interworking
// - Bit 4 latches interworking changes
// - Slip status bits 7..5 and 2..0
// - Pattern change enable bit 6, reset zero
`timescale 1ns/1ps
`default_nettype none
module sbi_irq
    import sbi_pkg::*;
#(
    parameter int unsigned TIMEOUT = IW_CYCLES
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [DAT_W-1:0] wb_dat_i,
    output logic [DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    // Slip buffer events
    input wire sbi_slip_ev_t tx_ev,
    input wire sbi_slip_ev_t rx_ev,
    // Receive framer status
    input wire logic alt_pattern_det,
    input wire logic basic_align,
    input wire logic crc_mf_align,
    // Slip actions toward the buffers
    output logic tx_frame_drop,
    output logic tx_frame_repeat,
    output logic rx_frame_drop,
    output logic rx_frame_repeat,
    // Interrupt
    output logic irq
);

    // Address match on a word index
    function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [13:0] idx);
        hit = (adr[ADR_W-1:2] == idx);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode

    logic ack_ff;
    logic [DAT_W-1:0] rdat_ff;
    logic req;
    logic wr;
    logic rd;
    logic [7:0] slip_st_ff;
    logic [7:0] slip_en_ff;
    logic [7:0] lc_en_ff;
    logic [7:0] cfg_ff;
    logic alt_flag_ff;
    logic iw_flag_ff;
    logic alt_prev_ff;
    logic iw_prev_ff;
    logic interwork_ff;
    logic [7:0] lc_st;
    logic [7:0] slip_set;
    logic [7:0] slip_clr;
    logic alt_chg;
    logic iw_chg;
    logic lc_clr_alt;
    logic lc_clr_iw;

    // One access per request, ack drops the cycle after
    assign req = wb_cyc_i && wb_stb_i && !ack_ff;
    assign wr = req && wb_we_i && wb_sel_i[0];
    assign rd = req && !wb_we_i;

    // Live view of the loopback-code status register
    always_comb
    begin
        lc_st = REG_RST;
        lc_st[B_ALT_PRESENT] = alt_pattern_det;
        lc_st[B_ALT_CHANGE] = alt_flag_ff;
        lc_st[B_IW_STATE] = interwork_ff;
        lc_st[B_IW_CHANGE] = iw_flag_ff;
    end

    // Ack and registered read data; unmapped reads return zero
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            ack_ff <= 1'b0;
            rdat_ff <= '0;
        end
        else
        begin
            ack_ff <= req;
            if (rd)
            begin
                rdat_ff <= '0;
                if (hit(wb_adr_i, IDX_SLIP_ST))
                    rdat_ff[7:0] <= slip_st_ff;
                else if (hit(wb_adr_i, IDX_SLIP_EN))
                    rdat_ff[7:0] <= slip_en_ff;
                else if (hit(wb_adr_i, IDX_LC_ST))
                    rdat_ff[7:0] <= lc_st;
                else if (hit(wb_adr_i, IDX_LC_EN))
                    rdat_ff[7:0] <= lc_en_ff;
                else if (hit(wb_adr_i, IDX_CFG))
                    rdat_ff[7:0] <= cfg_ff;
            end
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Enable and configuration registers

    // Reserved bits are masked off so they read zero
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            slip_en_ff <= REG_RST;
            lc_en_ff <= REG_RST;
            cfg_ff <= REG_RST;
        end
        else if (wr)
        begin
            if (hit(wb_adr_i, IDX_SLIP_EN))
                slip_en_ff <= wb_dat_i[7:0] & SLIP_MASK;
            if (hit(wb_adr_i, IDX_LC_EN))
                lc_en_ff <= wb_dat_i[7:0] & LC_EN_MASK;
            if (hit(wb_adr_i, IDX_CFG))
                cfg_ff <= wb_dat_i[7:0] & CFG_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Slip status flags

    // Slip flag set by either condition in its direction
    always_comb
    begin
        slip_set = REG_RST;
        slip_set[B_TX_FULL] = tx_ev.full_wr;
        slip_set[B_TX_EMPTY] = tx_ev.empty_rd;
        slip_set[B_TX_SLIP] = tx_ev.full_wr || tx_ev.empty_rd;
        slip_set[B_RX_FULL] = rx_ev.full_wr;
        slip_set[B_RX_EMPTY] = rx_ev.empty_rd;
        slip_set[B_RX_SLIP] = rx_ev.full_wr || rx_ev.empty_rd;
    end

    // Read clears all flags, write clears the ones written as one
    always_comb
    begin
        slip_clr = REG_RST;
        if (rd && hit(wb_adr_i, IDX_SLIP_ST))
            slip_clr = SLIP_MASK;
        else if (wr && hit(wb_adr_i, IDX_SLIP_ST))
            slip_clr = wb_dat_i[7:0] & SLIP_MASK;
    end

    // Set beats clear so no event is lost during a read
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            slip_st_ff <= REG_RST;
        else
            slip_st_ff <= ((slip_st_ff & ~slip_clr) | slip_set) & SLIP_MASK;
    end

    // Frame drop and repeat commands to the buffer datapath
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            tx_frame_drop <= 1'b0;
            tx_frame_repeat <= 1'b0;
            rx_frame_drop <= 1'b0;
            rx_frame_repeat <= 1'b0;
        end
        else
        begin
            tx_frame_drop <= tx_ev.full_wr;
            tx_frame_repeat <= tx_ev.empty_rd;
            rx_frame_drop <= rx_ev.full_wr;
            rx_frame_repeat <= rx_ev.empty_rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pattern and interworking change flags

    sbi_iw_timer #(
        .TIMEOUT(TIMEOUT)
    ) u_iw (
        .mclk(mclk),
        .nrst(nrst),
        .hunt_en(cfg_ff[B_ANNEX_B] && cfg_ff[B_CRC4_EN]),
        .basic_align(basic_align),
        .crc_mf_align(crc_mf_align),
        .interwork_ff(interwork_ff)
    );

    // Edges in either direction count as a change
    assign alt_chg = alt_pattern_det ^ alt_prev_ff;
    assign iw_chg = interwork_ff ^ iw_prev_ff;
    assign lc_clr_alt = (rd && hit(wb_adr_i, IDX_LC_ST)) ||
        (wr && hit(wb_adr_i, IDX_LC_ST) && wb_dat_i[B_ALT_CHANGE]);
    assign lc_clr_iw = (rd && hit(wb_adr_i, IDX_LC_ST)) ||
        (wr && hit(wb_adr_i, IDX_LC_ST) && wb_dat_i[B_IW_CHANGE]);

    // Previous levels; pattern starts absent so a present level at reset flags
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            alt_prev_ff <= 1'b0;
            iw_prev_ff <= 1'b0;
        end
        else
        begin
            alt_prev_ff <= alt_pattern_det;
            iw_prev_ff <= interwork_ff;
        end
    end

    // Sticky change flags, set wins over clear
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            alt_flag_ff <= 1'b0;
            iw_flag_ff <= 1'b0;
        end
        else
        begin
            alt_flag_ff <= alt_chg || (alt_flag_ff && !lc_clr_alt);
            iw_flag_ff <= iw_chg || (iw_flag_ff && !lc_clr_iw);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt output

    // Registered, so it follows the flags by one cycle
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            irq <= 1'b0;
        else
            irq <= |(slip_st_ff & slip_en_ff) ||
                (alt_flag_ff && lc_en_ff[B_ALT_CHANGE]) ||
                (iw_flag_ff && lc_en_ff[B_IW_CHANGE]);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    tx_full_set_a: assert property (@(posedge mclk) disable iff (!nrst)
        tx_ev.full_wr |=> slip_st_ff[B_TX_FULL] && slip_st_ff[B_TX_SLIP] && tx_frame_drop)
        else $error("tx full write did not flag and drop");

    tx_empty_set_a: assert property (@(posedge mclk) disable iff (!nrst)
        tx_ev.empty_rd |=> slip_st_ff[B_TX_EMPTY] && tx_frame_repeat)
        else $error("tx empty read did not flag and repeat");

    rx_full_set_a: assert property (@(posedge mclk) disable iff (!nrst)
        rx_ev.full_wr |=> slip_st_ff[B_RX_FULL] && rx_frame_drop)
        else $error("rx full write did not flag and drop");

    rx_empty_set_a: assert property (@(posedge mclk) disable iff (!nrst)
        rx_ev.empty_rd |=> slip_st_ff[B_RX_EMPTY] && slip_st_ff[B_RX_SLIP] && rx_frame_repeat)
        else $error("rx empty read did not flag and repeat");

    slip_only_a: assert property (@(posedge mclk) disable iff (!nrst)
        $rose(slip_st_ff[B_TX_SLIP]) |-> $past(tx_ev.full_wr || tx_ev.empty_rd))
        else $error("tx slip flag rose without a slip event");

    reserved_zero_a: assert property (@(posedge mclk) disable iff (!nrst)
        ack_ff && !wb_we_i |-> rdat_ff[DAT_W-1:8] == '0 &&
            (!hit(wb_adr_i, IDX_SLIP_EN) || rdat_ff[4:3] == 2'b00) &&
            (!hit(wb_adr_i, IDX_LC_ST) || rdat_ff[3:0] == 4'h0))
        else $error("reserved bits read nonzero");

    read_clear_a: assert property (@(posedge mclk) disable iff (!nrst)
        rd && hit(wb_adr_i, IDX_SLIP_ST) && slip_set == REG_RST
        |=> slip_st_ff == REG_RST && rdat_ff[7:0] == $past(slip_st_ff))
        else $error("slip status read did not clear");

    alt_change_a: assert property (@(posedge mclk) disable iff (!nrst)
        alt_pattern_det != $past(alt_pattern_det) |=> alt_flag_ff)
        else $error("pattern change not latched");

    iw_change_a: assert property (@(posedge mclk) disable iff (!nrst)
        $changed(interwork_ff) |=> iw_flag_ff)
        else $error("interworking change not latched");

    irq_level_a: assert property (@(posedge mclk) disable iff (!nrst)
        ##1 irq == $past(|(slip_st_ff & slip_en_ff) ||
            (alt_flag_ff && lc_en_ff[B_ALT_CHANGE]) || (iw_flag_ff && lc_en_ff[B_IW_CHANGE])))
        else $error("interrupt does not follow enabled flags");

    ack_pulse_a: assert property (@(posedge mclk) disable iff (!nrst)
        ack_ff |=> !ack_ff)
        else $error("ack held longer than one cycle");

endmodule
`default_nettype wire

// [src/sbi_pkg.sv]
// Purpose: Shared constants and types for the slip and interworking interrupt block
// Assumes: 200 MHz mclk, classic Wishbone slave with 32-bit data
// Notes: Register indices are word indices; the byte address is four times the index
package sbi_pkg;

    // Clock rate and interworking timeout
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned IW_TIME_MS = 400;
    localparam int unsigned IW_CYCLES = IW_TIME_MS * (CLK_HZ / 1000);

    // Bus geometry
    localparam int unsigned ADR_W = 16;
    localparam int unsigned DAT_W = 32;

    // Register indices (byte address = index * 4)
    localparam logic [13:0] IDX_SLIP_ST = 14'h0B08;
    localparam logic [13:0] IDX_SLIP_EN = 14'h0B09;
    localparam logic [13:0] IDX_LC_ST = 14'h0B0A;
    localparam logic [13:0] IDX_LC_EN = 14'h0B0B;
    localparam logic [13:0] IDX_CFG = 14'h0107;

    // Slip status and enable bit positions
    localparam int unsigned B_TX_FULL = 7;
    localparam int unsigned B_TX_EMPTY = 6;
    localparam int unsigned B_TX_SLIP = 5;
    localparam int unsigned B_RX_FULL = 2;
    localparam int unsigned B_RX_EMPTY = 1;
    localparam int unsigned B_RX_SLIP = 0;
    localparam logic [7:0] SLIP_MASK = 8'hE7;

    // Loopback-code status and enable bit positions
    localparam int unsigned B_ALT_PRESENT = 7;
    localparam int unsigned B_ALT_CHANGE = 6;
    localparam int unsigned B_IW_STATE = 5;
    localparam int unsigned B_IW_CHANGE = 4;
    localparam logic [7:0] LC_EN_MASK = 8'h50;

    // Configuration bit positions
    localparam int unsigned B_ANNEX_B = 0;
    localparam int unsigned B_CRC4_EN = 1;
    localparam logic [7:0] CFG_MASK = 8'h03;

    // Reset values
    localparam logic [7:0] REG_RST = 8'h00;

    // One direction's slip events from the slip buffer
    typedef struct packed {
        logic full_wr;
        logic empty_rd;
    } sbi_slip_ev_t;

    // Interworking timer states, Gray coded along the path
    typedef enum logic [1:0] {
        IW_IDLE = 2'b00,
        IW_HUNT = 2'b01,
        IW_NONCRC = 2'b11
    } sbi_iw_state_t;

endpackage

// [src/sbi_iw_timer.sv]
// Purpose: Decides CRC-4 to non-CRC-4 interworking after a timeout
// Assumes: All inputs synchronous to mclk
// Notes: Timeout is a parameter so that simulation can shorten it
`timescale 1ns/1ps
`default_nettype none
module sbi_iw_timer
    import sbi_pkg::*;
#(
    parameter int unsigned TIMEOUT = IW_CYCLES
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Mode and alignment inputs
    input wire logic hunt_en,
    input wire logic basic_align,
    input wire logic crc_mf_align,
    // Result
    output logic interwork_ff
);

    localparam int unsigned CW = $clog2(TIMEOUT + 1);

    generate
        if (TIMEOUT < 1)
        begin : g_bad
            $error("TIMEOUT must be at least one cycle");
        end
    endgenerate

    sbi_iw_state_t st_ff;
    logic [CW-1:0] cnt_ff;

    // Hunt for multiframe alignment while basic alignment holds
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_ff <= IW_IDLE;
            cnt_ff <= '0;
        end
        else
        begin
            case (st_ff)
                IW_IDLE:
                begin
                    cnt_ff <= '0;
                    if (hunt_en && basic_align && !crc_mf_align)
                        st_ff <= IW_HUNT;
                end
                IW_HUNT:
                begin
                    // Losing either condition restarts the full window
                    if (!hunt_en || !basic_align || crc_mf_align)
                        st_ff <= IW_IDLE;
                    else if (cnt_ff == CW'(TIMEOUT - 1))
                        st_ff <= IW_NONCRC;
                    else
                        cnt_ff <= cnt_ff + CW'(1);
                end
                IW_NONCRC:
                begin
                    // Far end turned out CRC-4 capable, or mode left
                    if (!hunt_en || crc_mf_align)
                        st_ff <= IW_IDLE;
                end
                default:
                    st_ff <= IW_IDLE;
            endcase
        end
    end

    // Registered state output
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            interwork_ff <= 1'b0;
        else
            interwork_ff <= (st_ff == IW_NONCRC);
    end

endmodule
`default_nettype wire

// [tb/sbi_far_model.sv]
// Purpose: Far-side slip buffer stand-in that raises slip events
// Assumes: Bench commands change just after a rising mclk edge
// Notes: Each command bit is copied to its event one edge later, for as long as it is held
`timescale 1ns/1ps
`default_nettype none
module sbi_far_model
    import sbi_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Command: tx full, tx empty, rx full, rx empty
    input wire logic [3:0] cmd,
    // Slip events toward the block
    output var sbi_slip_ev_t tx_ev,
    output var sbi_slip_ev_t rx_ev
);
    // Registered so events never glitch near the sampling edge
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            tx_ev <= '0;
            rx_ev <= '0;
        end
        else
        begin
            tx_ev <= {cmd[3], cmd[2]};
            rx_ev <= {cmd[1], cmd[0]};
        end
    end
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Purpose: Self-checking bench for the slip and interworking interrupt block
// Assumes: 200 MHz mclk, Wishbone classic master driven on rising edges
// Notes: Timeout shortened to keep the interworking hunt brief
`timescale 1ns/1ps
`default_nettype none
module testbench
    import sbi_pkg::*;
;
    localparam int unsigned TMO = 20;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [ADR_W-1:0] adr = '0;
    logic [3:0] sel = 4'h0;
    logic [DAT_W-1:0] wdat = '0;
    logic [DAT_W-1:0] rdat;
    logic ack;
    logic [3:0] cmd = 4'h0;
    logic [3:0] wsel = 4'hF;
    sbi_slip_ev_t tx_ev;
    sbi_slip_ev_t rx_ev;
    logic alt = 1'b0;
    logic basic = 1'b0;
    logic crc = 1'b0;
    logic txd, txr, rxd, rxr, irq;
    logic [31:0] rd;
    logic [31:0] v;
    logic [3:0] cmds [6] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h9, 4'h6};
    logic [13:0] idxs [5] = '{IDX_SLIP_ST, IDX_SLIP_EN, IDX_LC_ST, IDX_LC_EN, IDX_CFG};
    int n_fail = 0;
    int checked = 0;

    ////////////////////////////////////////////////////////////
    // Clock, design and far side
    always #2.5 mclk = ~mclk;

    sbi_irq #(.TIMEOUT(TMO)) sbi_irq_inst (.mclk(mclk), .nrst(nrst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .tx_ev(tx_ev), .rx_ev(rx_ev), .alt_pattern_det(alt),
        .basic_align(basic), .crc_mf_align(crc), .tx_frame_drop(txd),
        .tx_frame_repeat(txr), .rx_frame_drop(rxd), .rx_frame_repeat(rxr),
        .irq(irq));

    sbi_far_model sbi_far_model_inst (.mclk(mclk), .nrst(nrst), .cmd(cmd),
        .tx_ev(tx_ev), .rx_ev(rx_ev));

    ////////////////////////////////////////////////////////////
    // Expected slip status: each event plus its direction slip bit
    function automatic logic [7:0] slip_exp(input logic [3:0] c);
        return {c[3], c[2], c[3] | c[2], 2'b00, c[1], c[0], c[1] | c[0]};
    endfunction

    // Single comparison point
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One classic cycle; holds until ack is sampled, no assumed latency
    task automatic wb(input logic w, input logic [13:0] idx, input logic [7:0] d,
        output logic [31:0] r);
        int n;
        n = 0;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= wsel;
        wdat <= {24'h0, d};
        @(posedge mclk);
        while (ack !== 1'b1 && n < 50)
        begin
            @(posedge mclk);
            n++;
        end
        if (n >= 50)
            n_fail++;
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge mclk);
    endtask

    // Read and compare low byte, upper bytes must be zero
    task automatic rdc(input logic [13:0] idx, input logic [7:0] e);
        logic [31:0] r;
        wb(1'b0, idx, 8'h00, r);
        chk(r, {24'h0, e});
    endtask

    // Fire slip events and check the frame actions one edge later
    task automatic pulse(input logic [3:0] c);
        @(posedge mclk);
        cmd <= c;
        @(posedge mclk);
        cmd <= 4'h0;
        @(posedge mclk);
        #1;
        chk(32'({txd, txr, rxd, rxr}), 32'(c));
    endtask

    task automatic report_and_stop();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    // Watchdog sized well above the expected run
    initial
    begin
        #100000;
        n_fail++;
        report_and_stop();
    end

    // Main sequence
    initial
    begin
        void'($urandom(73));
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        // Reset values of every register
        foreach (idxs[i])
            rdc(idxs[i], 8'h00);
        // Random enables; reserved bits stay zero
        repeat (4)
        begin
            v = $urandom;
            wb(1'b1, IDX_SLIP_EN, v[7:0], rd);
            rdc(IDX_SLIP_EN, v[7:0] & SLIP_MASK);
            wb(1'b1, IDX_LC_EN, v[15:8], rd);
            rdc(IDX_LC_EN, v[15:8] & LC_EN_MASK);
        end
        // Slip events, single and simultaneous, masked and enabled
        foreach (cmds[i])
        begin
            wb(1'b1, IDX_SLIP_EN, (i % 2) ? (slip_exp(cmds[i]) & 8'hDE) : 8'h00, rd);
            wb(1'b1, IDX_LC_EN, 8'h00, rd);
            pulse(cmds[i]);
            repeat (2) @(posedge mclk);
            #1;
            chk(32'(irq), 32'(i % 2));
            rdc(IDX_SLIP_ST, slip_exp(cmds[i]));
            rdc(IDX_SLIP_ST, 8'h00);
            #1;
            chk(32'(irq), 32'h0);
        end
        // Event in the very cycle a read clears: the set must survive
        fork
            rdc(IDX_SLIP_ST, 8'h00);
            begin
                cmd <= 4'h8;
                @(posedge mclk);
                cmd <= 4'h0;
            end
        join
        rdc(IDX_SLIP_ST, slip_exp(4'h8));
        // Write-one clears only the bits written; sel[0] low writes nothing
        pulse(4'h9);
        wb(1'b1, IDX_SLIP_ST, 8'h80, rd);
        rdc(IDX_SLIP_ST, slip_exp(4'h9) & 8'h7F);
        wsel = 4'hE;
        wb(1'b1, IDX_SLIP_EN, 8'h00, rd);
        wsel = 4'hF;
        rdc(IDX_SLIP_EN, slip_exp(cmds[5]) & 8'hDE);
        // Alternating pattern start and stop
        wb(1'b1, IDX_LC_EN, 8'h40, rd);
        alt <= 1'b1;
        repeat (2 + $urandom_range(3)) @(posedge mclk);
        #1;
        chk(32'(irq), 32'h1);
        rdc(IDX_LC_ST, 8'hC0);
        rdc(IDX_LC_ST, 8'h80);
        alt <= 1'b0;
        repeat (3) @(posedge mclk);
        rdc(IDX_LC_ST, 8'h40);
        rdc(IDX_LC_ST, 8'h00);
        // No interworking while the mode is off
        wb(1'b1, IDX_LC_EN, 8'h10, rd);
        basic <= 1'b1;
        repeat (2 * TMO) @(posedge mclk);
        rdc(IDX_LC_ST, 8'h00);
        // Annex B without CRC-4 enabled does not hunt either
        wb(1'b1, IDX_CFG, 8'h01, rd);
        repeat (2 * TMO) @(posedge mclk);
        rdc(IDX_LC_ST, 8'h00);
        // Hunt times out with basic alignment only
        wb(1'b1, IDX_CFG, 8'h03, rd);
        repeat (TMO - 6) @(posedge mclk);
        rdc(IDX_LC_ST, 8'h00);
        repeat (15) @(posedge mclk);
        #1;
        chk(32'(irq), 32'h1);
        rdc(IDX_LC_ST, 8'h30);
        // Multiframe lock returns to CRC-4 working
        crc <= 1'b1;
        repeat (5) @(posedge mclk);
        rdc(IDX_LC_ST, 8'h10);
        rdc(IDX_LC_ST, 8'h00);
        // Unmapped place acks with zero and keeps nothing
        wb(1'b1, 14'h0B0D, 8'hFF, rd);
        rdc(14'h0B0D, 8'h00);
        // Second reset mid-run with a flag pending and irq high
        pulse(4'h4);
        repeat (2) @(posedge mclk);
        #1;
        chk(32'(irq), 32'h1);
        nrst <= 1'b0;
        #1;
        chk(32'({irq, txd, txr, rxd, rxr}), 32'h0);
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        foreach (idxs[i])
            rdc(idxs[i], 8'h00);
        report_and_stop();
    end
endmodule
`default_nettype wire
